// File: rtl/rtx_ctrl_regs.svh
// offsets, field positions, reset values and timing counts of the tx control block
`ifndef RTX_CTRL_REGS_SVH
`define RTX_CTRL_REGS_SVH
// ============================================================
// Notes on behaviour
// - mode low keeps the transmitter in standby, mode high enables transmitter and clock output.
// - the mode input has a pull-down so a floating mode input shuts everything down.
// - clock output is the reference divided by 4 (divider select 0) or by 16 (select 1).
// - data 0 closes the pulling switch (lower frequency), data 1 opens it (upper frequency).
// - the output stage stays off until the synthesizer reports lock.
// - a low-supply detection forces the output stage off whatever power step is chosen.
// - after mode rises the output stage is held off for the start-up interval.
// - the start-up interval is 0.8 ms typical and never above 1.2 ms.
// - the power-select level is compared with four thresholds into a thermometer code.
// - the thermometer enables are gated by lock and by the low-supply detector.
// - in standby the power-select pin is left high impedance with its bias current off.
// - for amplitude keying the output stage follows the power-select level on and off.
// - the synthesizer feedback divider divides by 32.
// - the power-step comparators have about 20 mV hysteresis.

// ============================================================
// register map
`define RTX_OFF_CTRL     8'h00
`define RTX_OFF_BITDIV   8'h04
`define RTX_OFF_TXDATA   8'h08
`define RTX_OFF_STATUS   8'h0C
`define RTX_CTRL_SRC_BIT 0
`define RTX_CTRL_RST     32'h0000_0000
`define RTX_BITDIV_RST   16'h04E2

// ============================================================
// timing and ratios
`define RTX_PCLK_MHZ     50
`define RTX_TON_TYP_US   800
`define RTX_TON_MAX_US   1200
`define RTX_TON_CYC      (`RTX_TON_TYP_US * `RTX_PCLK_MHZ)
`define RTX_TON_MAX_CYC  (`RTX_TON_MAX_US * `RTX_PCLK_MHZ)
`define RTX_DIV_LO       4
`define RTX_DIV_HI       16
`define RTX_FB_DIV       32

// ============================================================
// power-select thresholds in mV
`define RTX_HYST_MV      12'h014
`define RTX_TH1_MV       12'h05A
`define RTX_TH2_MV       12'h12C
`define RTX_TH3_MV       12'h2B2
`define RTX_TH4_MV       12'h58C

`endif

// File: rtl/rtx_pkg.sv
// types shared by the tx control block
package rtx_pkg;
    typedef enum logic [2:0] {
        RTX_ST_STBY  = 3'b001,
        RTX_ST_START = 3'b010,
        RTX_ST_TX    = 3'b100
    } rtx_state_t;
endpackage

// File: rtl/rtx_fifo.sv
// synchronous fifo with valid/ready on both sides
module rtx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  full,
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    wire              push;
    wire              pop;

    // ============================================================
    // flags
    assign empty     = (wp_r == rp_r);
    assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rp_r[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ============================================================
    // pointers and storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop)  rp_r <= rp_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem[wp_r[AW-1:0]] <= in_data;
    end
endmodule // rtx_fifo

// File: rtl/rtx_ctrl.sv
// mode, clock output, fsk switch and power-step control of the transmitter
`include "rtx_ctrl_regs.svh"
module rtx_ctrl #(
    parameter int STARTUP_CYC = `RTX_TON_CYC,
    parameter int FIFO_W      = 8,
    parameter int FIFO_D      = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        mode_pin,
    input  wire logic        fsk_data_in,
    input  wire logic        clk_div_sel,
    input  wire logic        pll_lock,
    input  wire logic        low_supply_det,
    input  wire logic [11:0] psel_level_mv,
    output logic             mode_pull_down_on,
    output logic             tx_enable,
    output logic             clock_out_pin,
    output logic             pulling_switch_node,
    output logic             psel_bias_on,
    output logic      [3:0]  rf_output_stage,
    output logic             synth_fb_tick
);
    localparam logic [11:0] TH [4] = '{`RTX_TH1_MV, `RTX_TH2_MV, `RTX_TH3_MV, `RTX_TH4_MV};
    localparam logic [19:0] TON = 20'(STARTUP_CYC);

    // ============================================================
    // declarations
    rtx_pkg::rtx_state_t state_r;
    rtx_pkg::rtx_state_t state_nxt;
    logic [4:0]        s1_r;
    logic [4:0]        s2_r;
    logic [4:0]        s3_r;
    logic [4:0]        flt_r;
    logic [19:0]       tmr_r;
    logic [3:0]        ck_cnt_r;
    logic              clock_out_pin_r;
    logic [4:0]        fb_cnt_r;
    logic              fb_tick_r;
    logic [3:0]        therm_r;
    logic [3:0]        therm_nxt;
    logic [3:0]        rf_r;
    logic              sw_r;
    logic              bias_r;
    logic              src_fifo_r;
    logic [15:0]       bitdiv_r;
    logic [15:0]       bt_r;
    logic [FIFO_W-1:0] sh_r;
    logic [3:0]        bl_r;
    logic              fbit_r;
    logic [31:0]       prdata_r;
    logic [FIFO_W-1:0] f_out;
    logic              f_in_ready;
    logic              f_out_valid;
    logic              f_full;
    logic              f_empty;

    // ============================================================
    // pin synchronisers: a level counts once stages two and three agree
    wire [4:0] raw     = {low_supply_det, pll_lock, clk_div_sel, fsk_data_in, mode_pin};
    wire [4:0] flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));
    wire       mode_f  = flt_r[0];
    wire       fsk_f   = flt_r[1];
    wire       div_f   = flt_r[2];
    wire       lock_f  = flt_r[3];
    wire       lowv_f  = flt_r[4];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            flt_r <= '0;
        end else begin
            s1_r  <= raw;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            flt_r <= flt_nxt;
        end
    end

    // floating mode reads low through the pull-down and the reset value
    assign mode_pull_down_on = 1'b1;

    // ============================================================
    // mode state machine
    wire act    = (state_r != rtx_pkg::RTX_ST_STBY);
    wire in_tx  = (state_r == rtx_pkg::RTX_ST_TX);
    wire tmr_dn = (tmr_r <= 20'h00001);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            rtx_pkg::RTX_ST_STBY: begin
                if (mode_f) state_nxt = rtx_pkg::RTX_ST_START;
            end
            rtx_pkg::RTX_ST_START: begin
                if (!mode_f)     state_nxt = rtx_pkg::RTX_ST_STBY;
                else if (tmr_dn) state_nxt = rtx_pkg::RTX_ST_TX;
            end
            rtx_pkg::RTX_ST_TX: begin
                if (!mode_f) state_nxt = rtx_pkg::RTX_ST_STBY;
            end
            default: state_nxt = rtx_pkg::RTX_ST_STBY;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= rtx_pkg::RTX_ST_STBY;
            tmr_r   <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_r != rtx_pkg::RTX_ST_START) tmr_r <= TON;
            else if (!tmr_dn) tmr_r <= tmr_r - 20'h00001;
        end
    end

    assign tx_enable = act;

    // ============================================================
    // clock output divider, shared by both ratios
    wire [3:0] ck_cnt_nxt = ck_cnt_r + 4'h1;
    wire       ck_sel     = div_f ? ck_cnt_nxt[3] : ck_cnt_nxt[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_cnt_r <= '0;
            clock_out_pin_r  <= 1'b0;
        end else if (!act) begin
            ck_cnt_r <= '0;
            clock_out_pin_r  <= 1'b0;
        end else begin
            ck_cnt_r <= ck_cnt_nxt;
            clock_out_pin_r  <= ck_sel;
        end
    end

    assign clock_out_pin = clock_out_pin_r;

    // ============================================================
    // synthesizer feedback divide-by-32 tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_cnt_r  <= '0;
            fb_tick_r <= 1'b0;
        end else if (!act) begin
            fb_cnt_r  <= '0;
            fb_tick_r <= 1'b0;
        end else begin
            fb_cnt_r  <= fb_cnt_r + 5'h01;
            fb_tick_r <= (fb_cnt_r == 5'(`RTX_FB_DIV - 1));
        end
    end

    assign synth_fb_tick = fb_tick_r;

    // ============================================================
    // power-step comparators with hysteresis
    function automatic logic therm_bit(input logic cur, input logic [11:0] lvl,
                                       input logic [11:0] th);
        logic [12:0] up;
        up = {1'b0, lvl} + {1'b0, `RTX_HYST_MV};
        therm_bit = cur ? (up >= {1'b0, th}) : (lvl >= th);
    endfunction

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            therm_nxt[i] = act && therm_bit(therm_r[i], psel_level_mv, TH[i]);
        end
    end

    // lock, low supply and start-up all veto the stage
    wire       stage_ok = in_tx && lock_f && !lowv_f;
    wire [3:0] rf_nxt   = stage_ok ? therm_r : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            therm_r <= '0;
            rf_r    <= '0;
            bias_r  <= 1'b0;
        end else begin
            therm_r <= therm_nxt;
            rf_r    <= rf_nxt;
            bias_r  <= act;
        end
    end

    assign rf_output_stage = rf_r;
    assign psel_bias_on    = bias_r;

    // ============================================================
    // apb decode
    wire acc     = psel && penable;
    wire hit_ctl = (paddr == `RTX_OFF_CTRL);
    wire hit_bd  = (paddr == `RTX_OFF_BITDIV);
    wire hit_txd = (paddr == `RTX_OFF_TXDATA);
    wire hit_sts = (paddr == `RTX_OFF_STATUS);
    wire hit     = hit_ctl || hit_bd || hit_txd || hit_sts;
    wire txd_wr  = acc && pwrite && hit_txd;
    wire wr_ok   = acc && pwrite && pready;

    // a full fifo stalls the writer instead of dropping data
    assign pready  = !(txd_wr && !f_in_ready);
    assign pslverr = acc && !hit;
    assign prdata  = prdata_r;

    wire [31:0] sts = {21'h0, div_f, f_full, f_empty, therm_r, lowv_f, lock_f, in_tx, act};
    wire [31:0] rd_mux = hit_ctl ? {31'h0, src_fifo_r} :
                         hit_bd  ? {16'h0, bitdiv_r} :
                         hit_sts ? sts : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_fifo_r <= 1'(`RTX_CTRL_RST);
            bitdiv_r   <= `RTX_BITDIV_RST;
            prdata_r   <= '0;
        end else begin
            if (psel && !penable) prdata_r <= rd_mux;
            if (wr_ok && hit_ctl) src_fifo_r <= pwdata[`RTX_CTRL_SRC_BIT];
            if (wr_ok && hit_bd)  bitdiv_r   <= pwdata[15:0];
        end
    end

    // ============================================================
    // data fifo and bit serialiser
    // draining waits for lock after start-up, so writes may fill it early
    wire tx_go  = in_tx && lock_f && src_fifo_r;
    wire bt_z   = (bt_r == 16'h0000);
    wire bl_z   = (bl_r == 4'h0);
    wire f_pop  = tx_go && bt_z && bl_z && f_out_valid;
    wire [15:0] bt_ld = (bitdiv_r == 16'h0000) ? 16'h0000 : bitdiv_r - 16'h0001;

    rtx_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (txd_wr),
        .in_ready  (f_in_ready),
        .in_data   (pwdata[FIFO_W-1:0]),
        .out_valid (f_out_valid),
        .out_ready (f_pop),
        .out_data  (f_out),
        .full      (f_full),
        .empty     (f_empty)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bt_r   <= '0;
            sh_r   <= '0;
            bl_r   <= '0;
            fbit_r <= 1'b0;
        end else if (!tx_go) begin
            bt_r <= '0;
        end else if (!bt_z) begin
            bt_r <= bt_r - 16'h0001;
        end else if (!bl_z) begin
            bt_r   <= bt_ld;
            fbit_r <= sh_r[FIFO_W-1];
            sh_r   <= sh_r << 1;
            bl_r   <= bl_r - 4'h1;
        end else if (f_out_valid) begin
            bt_r   <= bt_ld;
            fbit_r <= f_out[FIFO_W-1];
            sh_r   <= f_out << 1;
            bl_r   <= 4'(FIFO_W - 1);
        end
    end

    // ============================================================
    // pulling switch: closed for a zero, open for a one
    wire fsk_bit = src_fifo_r ? fbit_r : fsk_f;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sw_r <= 1'b0;
        else          sw_r <= act && !fsk_bit;
    end

    assign pulling_switch_node = sw_r;

    // ============================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // outputs are registered, so they clear one edge after standby is entered
    AST_STBY_QUIET: assert property (
        !act |=> (rf_r == 4'h0) && !fb_tick_r
    ) else $error("output stage or synthesizer active in standby");

    AST_STBY_CLK_LOW: assert property (
        !act |=> !clock_out_pin_r && (ck_cnt_r == 4'h0)
    ) else $error("clock output not parked low in standby");

    AST_DIV4_PERIOD: assert property (
        ($rose(clock_out_pin_r) && !div_f && !$past(div_f) && act) ##1 (!div_f && act)[*4]
            |-> $rose(clock_out_pin_r)
    ) else $error("divide-by-4 clock period wrong");

    AST_DIV16_HIGH: assert property (
        ($rose(clock_out_pin_r) && div_f && $past(div_f) && act) ##1 (div_f && act)[*7]
            |-> clock_out_pin_r ##1 !clock_out_pin_r
    ) else $error("divide-by-16 clock high phase wrong");

    AST_FSK_SWITCH: assert property (
        act && !fsk_bit ##1 act |-> sw_r
    ) else $error("pulling switch open for a zero");

    AST_LOCK_GATE: assert property (
        !lock_f |=> rf_r == 4'h0
    ) else $error("output stage on without lock");

    AST_LOWV_GATE: assert property (
        lowv_f |=> rf_r == 4'h0
    ) else $error("output stage on at low supply");

    AST_START_HOLD: assert property (
        (state_r == rtx_pkg::RTX_ST_START) |=> (rf_r == 4'h0)
    ) else $error("output stage on during start-up");

    AST_TON_LOAD: assert property (
        (state_r == rtx_pkg::RTX_ST_STBY) && mode_f |=>
            (state_r == rtx_pkg::RTX_ST_START) && (tmr_r == TON) && (TON <= `RTX_TON_MAX_CYC)
    ) else $error("start-up interval not loaded");

    AST_TON_END: assert property (
        (state_r == rtx_pkg::RTX_ST_START) && mode_f && !tmr_dn |=>
            state_r != rtx_pkg::RTX_ST_TX
    ) else $error("start-up interval cut short");

    AST_THERMO: assert property (
        therm_r inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF}
    ) else $error("power step code not thermometer");

    AST_GATE_PASS: assert property (
        stage_ok |=> rf_r == $past(therm_r)
    ) else $error("thermometer enables not passed when allowed");

    AST_HYST_HOLD: assert property (
        act && therm_r[0] && (psel_level_mv + `RTX_HYST_MV >= `RTX_TH1_MV) |=> therm_r[0]
    ) else $error("lowest step dropped inside hysteresis");

    AST_BIAS_OFF: assert property (
        !act |=> !bias_r
    ) else $error("power-select bias on in standby");

    AST_FB_GAP: assert property (
        fb_tick_r |=> !fb_tick_r [*8]
    ) else $error("feedback ticks too close");

    AST_FULL_STALL: assert property (
        txd_wr && f_full |-> !pready
    ) else $error("write to full fifo not stalled");

    COV_REACH_TX: cover property (
        (state_r == rtx_pkg::RTX_ST_START) ##1 (state_r == rtx_pkg::RTX_ST_TX)
    );

    COV_FULL_STALL: cover property (txd_wr && !pready);

    COV_MAX_POWER: cover property (rf_r == 4'hF);

    COV_FIFO_KEYING: cover property (f_pop ##1 sw_r);
endmodule // rtx_ctrl

// File: verification/rtx_host_model.sv
// host microcontroller model driving the transmitter's pins
module rtx_host_model #(
    parameter int START_CYC = 20,
    parameter int BIT_CYC   = 1250
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        cmd_mode,
    input  wire logic        cmd_data,
    input  wire logic        cmd_div,
    input  wire logic [11:0] cmd_level,
    output logic             mode_pin,
    output logic             fsk_data_in,
    output logic             clk_div_sel,
    output logic [11:0]      psel_level_mv
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_r;
    int bit_r;
    // ========
    // pin drivers, changed just after each edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_pin      <= 1'b0;
            fsk_data_in   <= 1'b1;
            clk_div_sel   <= 1'b0;
            psel_level_mv <= 12'h000;
            wait_r        <= 0;
            bit_r         <= 0;
        end else begin
            mode_pin      <= cmd_mode;
            clk_div_sel   <= cmd_div;
            psel_level_mv <= cmd_level;
            wait_r        <= !cmd_mode ? 0 : (wait_r < START_CYC + 8 ? wait_r + 1 : wait_r);
            bit_r         <= (bit_r >= BIT_CYC - 1) ? 0 : bit_r + 1;
            // data idles high until start-up and lock have had time
            if (wait_r < START_CYC + 8)
                fsk_data_in <= 1'b1;
            else if (bit_r == 0)
                fsk_data_in <= cmd_data;
        end
    end
endmodule // rtx_host_model

// File: verification/tb_rf_tx_mode_clock_power_control.sv
// self-checking bench of the tx mode, clock and power control block
`include "rtx_ctrl_regs.svh"
module tb_rf_tx_mode_clock_power_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int START = 20;
    localparam int BIT   = 1250;
    localparam int LIMIT = 40000;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pll_lock, low_supply_det, mode_pin, fsk_data_in, clk_div_sel, pull_dn;
    logic        tx_enable, clock_out_pin, pulling_switch_node, psel_bias_on, fb_tick;
    logic        cmd_mode, cmd_data, cmd_div;
    logic [11:0] cmd_level, psel_level_mv;
    logic [3:0]  rf_output_stage, therm;
    logic [7:0]  rnd = 8'h1C;
    int          num_errors = 0, total_checks = 0, cycles = 0, n;
    int          lvl_tab[10] = '{0, 100, 400, 800, 1500, 1410, 1399, 300, 281, 279};
    int          th_tab[4] = '{90, 300, 690, 1420};
    int          m;
    logic        logging = 1'b0;
    logic [7:0]  sent[$];
    logic        sw_log[$];

    always #10 pclk = ~pclk;

    rtx_host_model #(.START_CYC(START), .BIT_CYC(BIT)) i_host (.pclk(pclk), .presetn(presetn),
        .cmd_mode(cmd_mode), .cmd_data(cmd_data), .cmd_div(cmd_div), .cmd_level(cmd_level),
        .mode_pin(mode_pin), .fsk_data_in(fsk_data_in), .clk_div_sel(clk_div_sel),
        .psel_level_mv(psel_level_mv));

    rtx_ctrl #(.STARTUP_CYC(START)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_pin(mode_pin), .fsk_data_in(fsk_data_in),
        .clk_div_sel(clk_div_sel), .pll_lock(pll_lock), .low_supply_det(low_supply_det),
        .psel_level_mv(psel_level_mv), .mode_pull_down_on(pull_dn), .tx_enable(tx_enable),
        .clock_out_pin(clock_out_pin), .pulling_switch_node(pulling_switch_node),
        .psel_bias_on(psel_bias_on), .rf_output_stage(rf_output_stage),
        .synth_fb_tick(fb_tick));

    // ========
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // comparator model, hysteresis sits below each threshold
    function automatic logic [3:0] therm_next(input int lvl, input logic [3:0] t);
        for (int k = 0; k < 4; k++) begin
            if (lvl >= th_tab[k])
                t[k] = 1'b1;
            else if (lvl + 20 < th_tab[k])
                t[k] = 1'b0;
        end
        return t;
    endfunction

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic high_run(output int h);
        h = 0;
        while (clock_out_pin !== 1'b0) @(posedge pclk);
        while (clock_out_pin !== 1'b1) @(posedge pclk);
        while (clock_out_pin === 1'b1) begin
            @(posedge pclk);
            h++;
        end
    endtask

    // switch trace while the fifo drains, checked against the bytes sent
    always @(posedge pclk) begin
        if (logging)
            sw_log.push_back(pulling_switch_node);
    end

    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            end_sim();
        end
    end

    // ========
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {pll_lock, low_supply_det, cmd_mode, cmd_div, cmd_level} = '0;
        cmd_data = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk("pull_down", pull_dn, 1);
        chk("reset_out", {tx_enable, clock_out_pin, psel_bias_on, rf_output_stage}, 0);
        apb(0, `RTX_OFF_CTRL, 0, rd, err);
        chk("ctrl_rst", rd, `RTX_CTRL_RST);
        apb(0, `RTX_OFF_BITDIV, 0, rd, err);
        chk("bitdiv_rst", rd, `RTX_BITDIV_RST);
        apb(1, 8'h10, 32'hFFFF_FFFF, rd, err);
        chk("unmapped_wr", err, 1);
        apb(0, 8'h10, 0, rd, err);
        chk("unmapped_rd", {err, rd}, 33'h1_0000_0000);
        // start-up: stage held off, then on with lock
        pll_lock  <= 1'b1;
        cmd_level <= 12'h5DC;
        cmd_mode  <= 1'b1;
        n = 0;
        while (tx_enable !== 1'b1) @(posedge pclk);
        for (int i = 0; i < 30; i++) begin
            @(posedge pclk);
            if (rf_output_stage !== 4'h0 && n == 0)
                n = i + 1;
        end
        chk("startup_len", n >= START && n <= START + 4, 1);
        chk("bias_on", psel_bias_on, 1);
        apb(0, `RTX_OFF_STATUS, 0, rd, err);
        chk("status", rd[7:0], 8'hF7);
        for (int s = 0; s < 2; s++) begin
            cmd_div <= s[0];
            repeat (40) @(posedge pclk);
            high_run(n);
            chk("clk_half", n, s ? 8 : 2);
        end
        while (fb_tick !== 1'b1) @(posedge pclk);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (fb_tick !== 1'b1);
        chk("fb_div", n, 32);
        // amplitude keying and hysteresis walk
        therm = 4'hF;
        foreach (lvl_tab[i]) begin
            cmd_level <= lvl_tab[i][11:0];
            therm = therm_next(lvl_tab[i], therm);
            repeat (8) @(posedge pclk);
            chk("therm", rf_output_stage, therm);
        end
        cmd_level <= 12'h5DC;
        pll_lock  <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("no_lock", rf_output_stage, 0);
        pll_lock       <= 1'b1;
        low_supply_det <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("low_supply", rf_output_stage, 0);
        low_supply_det <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("gate_open", rf_output_stage, 4'hF);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            cmd_data <= rnd[0];
            repeat (BIT + 10) @(posedge pclk);
            chk("switch", pulling_switch_node, !rnd[0]);
        end
        // fifo fills while unlocked, refuses, then drains
        pll_lock <= 1'b0;
        apb(1, `RTX_OFF_BITDIV, 2, rd, err);
        apb(1, `RTX_OFF_CTRL, 1, rd, err);
        repeat (8) @(posedge pclk);
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            apb(1, `RTX_OFF_TXDATA, {24'h0, rnd}, rd, err);
            sent.push_back(rnd);
        end
        apb(0, `RTX_OFF_STATUS, 0, rd, err);
        chk("fifo_full", rd[9:8], 2'b10);
        sent.push_back(8'hA5);
        fork
            apb(1, `RTX_OFF_TXDATA, 32'h0000_00A5, rd, err);
            begin
                repeat (10) @(posedge pclk);
                chk("stall", pready, 0);
                pll_lock <= 1'b1;
                logging  <= 1'b1;
            end
        join
        n  = 0;
        rd = '0;
        while (rd[8] !== 1'b1 && n < 300) begin
            apb(0, `RTX_OFF_STATUS, 0, rd, err);
            n++;
        end
        chk("fifo_empty", rd[9:8], 2'b01);
        // last byte still shifts after the fifo reads empty
        repeat (24) @(posedge pclk);
        logging <= 1'b0;
        // bits msb first, two cycles each at a divider of 2
        n = -1;
        for (int off = 0; off < 40 && n < 0; off++) begin
            m = 0;
            for (int k = 0; k < 8 * sent.size(); k++) begin
                if (off + 2 * k + 1 >= sw_log.size())
                    m++;
                else if (sw_log[off + 2 * k] !== !sent[k / 8][7 - k % 8] ||
                         sw_log[off + 2 * k + 1] !== !sent[k / 8][7 - k % 8])
                    m++;
            end
            if (m == 0)
                n = off;
        end
        chk("fifo_stream", n >= 0, 1);
        cmd_mode <= 1'b0;
        repeat (10) @(posedge pclk);
        chk("standby", {tx_enable, clock_out_pin, psel_bias_on, pulling_switch_node,
            rf_output_stage}, 0);
        end_sim();
    end
endmodule // tb_rf_tx_mode_clock_power_control
